// ==== accel_sample_fifo_control_tb.sv ====
// Self-checking bench for the accelerometer sample buffer
`timescale 1ns/1ns
`include "asf_map.svh"

module accel_sample_fifo_control_tb;
    localparam logic [7:0] A_CTL = `ASF_ADDR_MODE_CTRL;
    localparam logic [7:0] A_ST = `ASF_ADDR_STATUS;
    localparam logic [7:0] A_CNT = `ASF_ADDR_FILL_LOW;
    localparam logic [7:0] A_X = `ASF_ADDR_OUT_XL;
    logic        clk;
    logic        rst_b;
    logic        tick;
    logic        mag_on;
    logic        ev;
    logic        wm1_en;
    logic        wm2_en;
    logic        full_en;
    logic [15:0] ax;
    logic [15:0] ay;
    logic [15:0] az;
    logic [13:0] mag;
    logic [7:0]  addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic        wr;
    logic        rd_s;
    logic        rd_d;
    logic        pin1;
    logic        pin2;
    logic        cs_pu;
    logic [47:0] arr [0:299];
    logic [7:0]  exp_q [$];
    int          miscompares;
    int          total_checks;
    int          cycles;

    asf_sample_fifo #(.DEPTH(256)) asf_sample_fifo_i (
        .REF_CLK_I(clk), .RST_B_I(rst_b), .ODR_TICK_I(tick),
        .ACCEL_X_I(ax), .ACCEL_Y_I(ay), .ACCEL_Z_I(az),
        .MAGNITUDE_I(mag), .MAGNITUDE_ON_I(mag_on), .EVENT_IRQ_I(ev),
        .WATERMARK_TO_PIN1_ENABLE_I(wm1_en),
        .WATERMARK_TO_PIN2_ENABLE_I(wm2_en),
        .FULL_TO_PIN1_ENABLE_I(full_en),
        .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr),
        .REG_RD_I(rd_s), .REG_RDATA_O(rdata),
        .ACCEL_IRQ_PIN_ONE_O(pin1), .ACCEL_IRQ_PIN_TWO_O(pin2),
        .CHIP_SELECT_PULLUP_DISABLE_O(cs_pu));

    asf_host_model asf_host_model_i (
        .clk_i(clk), .addr_o(addr), .wdata_o(wdata), .wr_o(wr),
        .rd_o(rd_s));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic print_verdict;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string n, input logic [7:0] s,
                         input logic [7:0] e);
        total_checks++;
        if (s !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask

    // Read data stands one cycle after the read edge
    always @(posedge clk) begin
        rd_d <= rd_s;
        cycles <= cycles + 1;
        if (rd_d) begin
            check("reg_rdata", rdata, exp_q.pop_front());
        end
        if (cycles == 6000) begin
            miscompares++;
            print_verdict();
        end
    end

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        asf_host_model_i.bus_read(a);
    endtask

    task automatic wr_ctl(input logic [7:0] d);
        asf_host_model_i.bus_write(A_CTL, d);
    endtask

    task automatic rd_set(input int k);
        for (int i = 0; i < 6; i++) begin
            rd(A_X + 8'(i), arr[k][8*i +: 8]);
        end
    endtask

    task automatic run_ticks(input int base, input int n);
        for (int i = base; i < base + n; i++) begin
            arr[i] = {16'($urandom), 16'($urandom), 16'($urandom)};
            @(posedge clk);
            tick <= 1'b1;
            ax <= arr[i][15:0];
            ay <= arr[i][31:16];
            az <= arr[i][47:32];
            mag <= 14'($urandom);
            @(posedge clk);
            tick <= 1'b0;
        end
    endtask

    initial begin
        rst_b = 1'b0;
        tick = 1'b0;
        ax = 16'h0000;
        ay = 16'h0000;
        az = 16'h0000;
        mag = 14'h0000;
        mag_on = 1'b0;
        ev = 1'b0;
        wm1_en = 1'b0;
        wm2_en = 1'b0;
        full_en = 1'b0;
        rd_d = 1'b0;
        miscompares = 0;
        total_checks = 0;
        cycles = 0;
        void'($urandom(32'h07c56abd));
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        rd(A_CTL, `ASF_CTRL_RESET);
        rd(A_ST, 8'h80);
        asf_host_model_i.bus_write(A_CNT, 8'h55);
        rd(A_CNT, 8'h00);
        rd(8'h40, 8'h00);
        run_ticks(0, 2);
        rd(A_CNT, 8'h00);
        asf_host_model_i.bus_write(`ASF_ADDR_WM_LEVEL, 8'h03);
        rd(`ASF_ADDR_WM_LEVEL, 8'h03);
        wr_ctl(8'hc1);
        wm1_en <= 1'b1;
        rd(A_CTL, 8'hc1);
        check("cs_pullup", {7'h00, cs_pu}, 8'h01);
        run_ticks(0, 2);
        rd(A_ST, 8'h00);
        check("pin_one", {7'h00, pin1}, 8'h00);
        run_ticks(2, 2);
        rd(A_ST, 8'h80);
        rd(A_CNT, 8'h04);
        check("pin_one", {7'h00, pin1}, 8'h01);
        check("pin_two", {7'h00, pin2}, 8'h00);
        rd_set(0);
        rd(A_CNT, 8'h03);
        rd_set(1);
        wr_ctl(8'h00);
        rd(A_CNT, 8'h00);
        rd(A_X, arr[2][7:0]);
        // Full routed to pin one so a handler could drain promptly
        wm1_en <= 1'b0;
        full_en <= 1'b1;
        wm2_en <= 1'b1;
        wr_ctl(8'h20);
        run_ticks(0, 255);
        check("pin_one", {7'h00, pin1}, 8'h00);
        run_ticks(255, 1);
        rd(A_ST, 8'ha0);
        rd(A_CNT, 8'h00);
        check("pin_one", {7'h00, pin1}, 8'h01);
        check("pin_two", {7'h00, pin2}, 8'h01);
        run_ticks(256, 3);
        rd(A_ST, 8'he0);
        rd_set(0);
        rd(A_ST, 8'h80);
        rd(A_CNT, 8'hff);
        wr_ctl(8'h00);
        wr_ctl(8'hc0);
        run_ticks(0, 257);
        rd(A_ST, 8'he0);
        rd_set(1);
        wr_ctl(8'h00);
        rd(A_X, arr[2][7:0]);
        wr_ctl(8'hc0);
        rd(`ASF_ADDR_OUT_ZH, arr[2][47:40]);
        rd(A_CNT, 8'h00);
        wr_ctl(8'h00);
        wr_ctl(8'h40);
        run_ticks(0, 3);
        rd(A_CNT, 8'h00);
        wr_ctl(8'h00);
        wr_ctl(8'h80);
        run_ticks(0, 2);
        rd(A_CNT, 8'h00);
        @(posedge clk);
        ev <= 1'b1;
        @(posedge clk);
        ev <= 1'b0;
        run_ticks(0, 2);
        rd(A_CNT, 8'h02);
        rd_set(0);
        wr_ctl(8'h00);
        mag_on <= 1'b1;
        wr_ctl(8'hc8);
        run_ticks(0, 6);
        rd(A_CNT, 8'h02);
        rd(A_ST, 8'h00);
        repeat (3) @(posedge clk);
        print_verdict();
    end
endmodule

// ==== asf_host_model.sv ====
// Host processor model driving the register port of the sample buffer
`timescale 1ns/1ns

module asf_host_model (
    input  wire logic       clk_i,
    output logic      [7:0] addr_o,
    output logic      [7:0] wdata_o,
    output logic            wr_o,
    output logic            rd_o
);
    initial begin
        addr_o = 8'h00;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end

    // Released lines show the inverse so stale values never look valid
    task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~d;
    endtask

    task automatic bus_read(input logic [7:0] a);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        addr_o <= ~a;
    endtask
endmodule

// ==== asf_map.svh ====
// Register offsets, field positions and reset values of the sample buffer
`ifndef ASF_MAP_SVH
`define ASF_MAP_SVH

`define ASF_ADDR_MODE_CTRL   8'h25
`define ASF_ADDR_OUT_XL      8'h28
`define ASF_ADDR_OUT_XH      8'h29
`define ASF_ADDR_OUT_YL      8'h2a
`define ASF_ADDR_OUT_YH      8'h2b
`define ASF_ADDR_OUT_ZL      8'h2c
`define ASF_ADDR_OUT_ZH      8'h2d
`define ASF_ADDR_WM_LEVEL    8'h2e
`define ASF_ADDR_STATUS      8'h2f
`define ASF_ADDR_FILL_LOW    8'h30

`define ASF_MODE_HI          7
`define ASF_MODE_LO          5
`define ASF_MAG_BIT          3
`define ASF_CSPU_BIT         0
`define ASF_ST_WM_BIT        7
`define ASF_ST_OVR_BIT       6
`define ASF_ST_MSB_BIT       5

`define ASF_CTRL_RESET       8'h00
`define ASF_WM_RESET         8'h00
`define ASF_STATUS_RESET     8'h80
`define ASF_ZERO_BYTE        8'h00
`define ASF_FULL_COUNT       9'h100
`define ASF_EMPTY_COUNT      9'h000
`define ASF_ONE_COUNT        9'h001
`define ASF_MAG_LAST_PHASE   2'h2

`define ASF_CODE_BYPASS      3'h0
`define ASF_CODE_STOP        3'h1
`define ASF_CODE_CONT_STOP   3'h3
`define ASF_CODE_BYP_CONT    3'h4
`define ASF_CODE_CONT        3'h6

`endif

// ==== asf_pkg.sv ====
// Types shared by the sample buffer
package asf_pkg;
    typedef enum logic [2:0] {
        ASF_BYPASS,
        ASF_STOP_FULL,
        ASF_CONT_TO_STOP,
        ASF_BYP_TO_CONT,
        ASF_CONTINUOUS
    } asf_mode_type;
endpackage

// ==== asf_sample_fifo.sv ====
// Accelerometer sample buffer with mode control, fill count and pin routing
//
// Notes on behaviour
// - Reset leaves buffer in bypass; storage starts once another mode is set, for bypass-to-cont only at the event.
// - Mode codes: 000 bypass, 001 stop, 011 cont-to-stop, 100 bypass-to-cont, 110 cont.
// - With magnitude store and computation enabled, magnitudes are stored, not axes.
// - Magnitude entries stored three per slot; count and level in 3-entry units.
// - Watermark flag high while fill count is at least the watermark level.
// - Count rises per stored set below full, falls per complete set read by host.
// - Status contents refreshed every cycle, so every tick, write and read.
// - Status bit7 watermark, bit6 overrun, bit5 count MSB, bits 4..0 zero.
// - Overrun set when a set arrives past 256 unread sets; cleared by first set read.
// - Fill count is nine bits: MSB in status, low byte in count register.
// - Watermark routed to pin one and pin two by separate enables.
// - Full condition drives pin one when its enable is set.
// - Overrun never reaches a pin; polling only.
// - Bypass clears buffer, freezes output registers, keeps buffer empty.
// - Stop mode fills 256 sets; after overrun contents stay unchanged.
// - Outside bypass the output registers show the oldest stored set.
// - Reading a set hands it out and loads the next oldest set.
// - Continuous mode overwrites the oldest set once full.
// - Combined modes switch behaviour when the routed event interrupt occurs.
`timescale 1ns/1ns
`include "asf_map.svh"

module asf_sample_fifo
    import asf_pkg::*;
#(
    parameter int DEPTH = 256
) (
    input  wire logic        REF_CLK_I,
    input  wire logic        RST_B_I,
    input  wire logic        ODR_TICK_I,
    input  wire logic [15:0] ACCEL_X_I,
    input  wire logic [15:0] ACCEL_Y_I,
    input  wire logic [15:0] ACCEL_Z_I,
    input  wire logic [13:0] MAGNITUDE_I,
    input  wire logic        MAGNITUDE_ON_I,
    input  wire logic        EVENT_IRQ_I,
    input  wire logic        WATERMARK_TO_PIN1_ENABLE_I,
    input  wire logic        WATERMARK_TO_PIN2_ENABLE_I,
    input  wire logic        FULL_TO_PIN1_ENABLE_I,
    input  wire logic [7:0]  REG_ADDR_I,
    input  wire logic [7:0]  REG_WDATA_I,
    input  wire logic        REG_WR_I,
    input  wire logic        REG_RD_I,
    output logic      [7:0]  REG_RDATA_O,
    output logic             ACCEL_IRQ_PIN_ONE_O,
    output logic             ACCEL_IRQ_PIN_TWO_O,
    output logic             CHIP_SELECT_PULLUP_DISABLE_O
);
    localparam int AW = $clog2(DEPTH);

    // Count is a fixed nine bits, so deeper buffers cannot be reported
    initial begin
        if (DEPTH != 256) begin
            $error("asf_sample_fifo: DEPTH must be 256");
        end
    end

    function automatic asf_mode_type mode_decode(input logic [2:0] code);
        case (code)
            `ASF_CODE_STOP:      mode_decode = ASF_STOP_FULL;
            `ASF_CODE_CONT_STOP: mode_decode = ASF_CONT_TO_STOP;
            `ASF_CODE_BYP_CONT:  mode_decode = ASF_BYP_TO_CONT;
            `ASF_CODE_CONT:      mode_decode = ASF_CONTINUOUS;
            default:             mode_decode = ASF_BYPASS;
        endcase
    endfunction

    function automatic logic [7:0] out_byte(input logic [47:0] set,
                                            input logic [7:0]  addr);
        case (addr)
            `ASF_ADDR_OUT_XL: out_byte = set[7:0];
            `ASF_ADDR_OUT_XH: out_byte = set[15:8];
            `ASF_ADDR_OUT_YL: out_byte = set[23:16];
            `ASF_ADDR_OUT_YH: out_byte = set[31:24];
            `ASF_ADDR_OUT_ZL: out_byte = set[39:32];
            default:          out_byte = set[47:40];
        endcase
    endfunction

    // Registers
    logic [7:0]    ctrl_ff,  nxt_ctrl;
    logic [7:0]    wm_ff,    nxt_wm;
    logic [7:0]    rdata_ff, nxt_rdata;
    // Buffer state
    logic [8:0]    count_ff, nxt_count;
    logic [AW-1:0] wr_ff,    nxt_wr;
    logic [AW-1:0] rd_ff,    nxt_rd;
    logic          ovr_ff,   nxt_ovr;
    logic          stop_ff,  nxt_stop;
    logic          trig_ff,  nxt_trig;
    logic [47:0]   out_ff,   nxt_out;
    logic [1:0]    phase_ff, nxt_phase;
    logic [31:0]   magbuf_ff, nxt_magbuf;
    logic [7:0]    status_ff, nxt_status;
    logic          pin1_ff,  nxt_pin1;
    logic          pin2_ff,  nxt_pin2;
    logic [47:0]   mem [DEPTH];

    asf_mode_type  mode;
    logic          active;
    logic          wraps;
    logic          mag_mode;
    logic          push;
    logic          pop;
    logic          full;
    logic          write_slot;
    logic [47:0]   wdata;
    logic          is_mapped_out;

    // Register port
    always_comb begin
        nxt_ctrl  = ctrl_ff;
        nxt_wm    = wm_ff;
        nxt_rdata = rdata_ff;
        if (REG_WR_I && REG_ADDR_I == `ASF_ADDR_MODE_CTRL) begin
            nxt_ctrl = `ASF_ZERO_BYTE;
            nxt_ctrl[`ASF_MODE_HI:`ASF_MODE_LO] =
                REG_WDATA_I[`ASF_MODE_HI:`ASF_MODE_LO];
            nxt_ctrl[`ASF_MAG_BIT]  = REG_WDATA_I[`ASF_MAG_BIT];
            nxt_ctrl[`ASF_CSPU_BIT] = REG_WDATA_I[`ASF_CSPU_BIT];
        end
        if (REG_WR_I && REG_ADDR_I == `ASF_ADDR_WM_LEVEL) begin
            nxt_wm = REG_WDATA_I;
        end
        if (REG_RD_I) begin
            case (REG_ADDR_I)
                `ASF_ADDR_MODE_CTRL: nxt_rdata = ctrl_ff;
                `ASF_ADDR_WM_LEVEL:  nxt_rdata = wm_ff;
                `ASF_ADDR_STATUS:    nxt_rdata = status_ff;
                `ASF_ADDR_FILL_LOW:  nxt_rdata = count_ff[7:0];
                `ASF_ADDR_OUT_XL, `ASF_ADDR_OUT_XH, `ASF_ADDR_OUT_YL,
                `ASF_ADDR_OUT_YH, `ASF_ADDR_OUT_ZL, `ASF_ADDR_OUT_ZH:
                    nxt_rdata = out_byte(out_ff, REG_ADDR_I);
                default:             nxt_rdata = `ASF_ZERO_BYTE;
            endcase
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            ctrl_ff  <= `ASF_CTRL_RESET;
            wm_ff    <= `ASF_WM_RESET;
            rdata_ff <= `ASF_ZERO_BYTE;
        end else begin
            ctrl_ff  <= nxt_ctrl;
            wm_ff    <= nxt_wm;
            rdata_ff <= nxt_rdata;
        end
    end

    // Mode decode and buffer control
    assign mode     = mode_decode(ctrl_ff[`ASF_MODE_HI:`ASF_MODE_LO]);
    assign mag_mode = ctrl_ff[`ASF_MAG_BIT] && MAGNITUDE_ON_I;
    assign full     = count_ff == `ASF_FULL_COUNT;
    // A set counts as read once its last byte leaves
    assign is_mapped_out = REG_RD_I && REG_ADDR_I == `ASF_ADDR_OUT_ZH;
    assign pop      = is_mapped_out && mode != ASF_BYPASS
                      && count_ff != `ASF_EMPTY_COUNT;

    always_comb begin
        case (mode)
            ASF_STOP_FULL:    begin active = 1'b1;    wraps = 1'b0;     end
            ASF_CONT_TO_STOP: begin active = 1'b1;    wraps = !trig_ff; end
            ASF_BYP_TO_CONT:  begin active = trig_ff; wraps = 1'b1;     end
            ASF_CONTINUOUS:   begin active = 1'b1;    wraps = 1'b1;     end
            default:          begin active = 1'b0;    wraps = 1'b0;     end
        endcase
    end

    // Magnitudes gather three to a slot, so slot units are 3 entries
    assign write_slot = ODR_TICK_I && active && !stop_ff
                        && (!mag_mode || phase_ff == `ASF_MAG_LAST_PHASE);
    assign wdata = mag_mode ? {MAGNITUDE_I, 2'h0, magbuf_ff}
                            : {ACCEL_Z_I, ACCEL_Y_I, ACCEL_X_I};
    assign push = write_slot && (!full || pop || wraps);

    always_comb begin
        nxt_count  = count_ff;
        nxt_wr     = wr_ff;
        nxt_rd     = rd_ff;
        nxt_ovr    = ovr_ff;
        nxt_stop   = stop_ff;
        nxt_trig   = trig_ff;
        nxt_out    = out_ff;
        nxt_phase  = phase_ff;
        nxt_magbuf = magbuf_ff;
        if (mode == ASF_BYPASS) begin
            nxt_count = `ASF_EMPTY_COUNT;
            nxt_wr    = '0;
            nxt_rd    = '0;
            nxt_ovr   = 1'b0;
            nxt_stop  = 1'b0;
            nxt_trig  = 1'b0;
            nxt_phase = '0;
        end else begin
            if (EVENT_IRQ_I && (mode == ASF_CONT_TO_STOP
                                || mode == ASF_BYP_TO_CONT)) begin
                nxt_trig = 1'b1;
            end
            if (ODR_TICK_I && active && !stop_ff && mag_mode) begin
                if (phase_ff == `ASF_MAG_LAST_PHASE) begin
                    nxt_phase = '0;
                end else begin
                    nxt_phase = phase_ff + 2'h1;
                    if (phase_ff == '0) begin
                        nxt_magbuf[15:0] = {MAGNITUDE_I, 2'h0};
                    end else begin
                        nxt_magbuf[31:16] = {MAGNITUDE_I, 2'h0};
                    end
                end
            end
            if (pop) begin
                nxt_rd    = rd_ff + 1'b1;
                nxt_count = count_ff - `ASF_ONE_COUNT;
            end
            if (push) begin
                nxt_wr = wr_ff + 1'b1;
                if (full && !pop) begin
                    nxt_rd = rd_ff + 1'b1;
                end else if (!full) begin
                    nxt_count = nxt_count + `ASF_ONE_COUNT;
                end
            end
            // Clear by a read wins over a fresh overwrite
            if (pop) begin
                nxt_ovr = 1'b0;
            end
            if (write_slot && full && !pop) begin
                nxt_ovr = 1'b1;
                if (!wraps) begin
                    nxt_stop = 1'b1;
                end
            end
            // Oldest set follows the read index; new data bypasses the array
            if (nxt_count != `ASF_EMPTY_COUNT) begin
                if (push && wr_ff == nxt_rd) begin
                    nxt_out = wdata;
                end else begin
                    nxt_out = mem[nxt_rd];
                end
            end
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (push) begin
            mem[wr_ff] <= wdata;
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            count_ff  <= `ASF_EMPTY_COUNT;
            wr_ff     <= '0;
            rd_ff     <= '0;
            ovr_ff    <= 1'b0;
            stop_ff   <= 1'b0;
            trig_ff   <= 1'b0;
            out_ff    <= '0;
            phase_ff  <= '0;
            magbuf_ff <= '0;
        end else begin
            count_ff  <= nxt_count;
            wr_ff     <= nxt_wr;
            rd_ff     <= nxt_rd;
            ovr_ff    <= nxt_ovr;
            stop_ff   <= nxt_stop;
            trig_ff   <= nxt_trig;
            out_ff    <= nxt_out;
            phase_ff  <= nxt_phase;
            magbuf_ff <= nxt_magbuf;
        end
    end

    // Status and pins, refreshed every cycle from the new buffer state
    always_comb begin
        nxt_status = `ASF_ZERO_BYTE;
        // Next level too, so a level write is seen with the count it meets
        nxt_status[`ASF_ST_WM_BIT]  = nxt_count >= {1'b0, nxt_wm};
        nxt_status[`ASF_ST_OVR_BIT] = nxt_ovr;
        nxt_status[`ASF_ST_MSB_BIT] = nxt_count[8];
        nxt_pin1 = (nxt_status[`ASF_ST_WM_BIT] && WATERMARK_TO_PIN1_ENABLE_I)
                   || (nxt_count[8] && FULL_TO_PIN1_ENABLE_I);
        nxt_pin2 = nxt_status[`ASF_ST_WM_BIT]
                   && WATERMARK_TO_PIN2_ENABLE_I;
    end

    always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            // Empty count meets the reset level, so the flag starts high
            status_ff <= `ASF_STATUS_RESET;
            pin1_ff   <= 1'b0;
            pin2_ff   <= 1'b0;
        end else begin
            status_ff <= nxt_status;
            pin1_ff   <= nxt_pin1;
            pin2_ff   <= nxt_pin2;
        end
    end

    assign REG_RDATA_O                  = rdata_ff;
    assign ACCEL_IRQ_PIN_ONE_O          = pin1_ff;
    assign ACCEL_IRQ_PIN_TWO_O          = pin2_ff;
    assign CHIP_SELECT_PULLUP_DISABLE_O = ctrl_ff[`ASF_CSPU_BIT];

    bypass_empty_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
        mode == ASF_BYPASS |=> count_ff == `ASF_EMPTY_COUNT)
        else $error("count not cleared in bypass");
    wm_flag_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
        status_ff[`ASF_ST_WM_BIT] == (count_ff >= {1'b0, wm_ff}))
        else $error("watermark flag disagrees with count");
    count_step_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
        mode != ASF_BYPASS && push && !pop && !full
        |=> count_ff == $past(count_ff) + `ASF_ONE_COUNT)
        else $error("count did not step up on write");
    pop_step_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
        pop && !push |=> count_ff == $past(count_ff) - `ASF_ONE_COUNT)
        else $error("count did not step down on read");
    ovr_clear_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
        pop && !(write_slot && full) |=> !ovr_ff)
        else $error("overrun not cleared by read");
    stop_hold_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
        stop_ff && mode == ASF_STOP_FULL && !pop |=> $stable(wr_ff))
        else $error("stopped buffer still written");
    pin_two_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
        ACCEL_IRQ_PIN_TWO_O == (status_ff[`ASF_ST_WM_BIT]
                                && $past(WATERMARK_TO_PIN2_ENABLE_I)))
        else $error("pin two routing wrong");
    status_low_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
        status_ff[4:0] == 5'h00 && status_ff[`ASF_ST_MSB_BIT] == count_ff[8])
        else $error("status layout wrong");
    empty_read_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
        count_ff == `ASF_EMPTY_COUNT && !push |=> $stable(out_ff))
        else $error("output moved while empty");
endmodule
